// ---- design/plp_regs.sv ----
// LED control and PHY general control registers with the LED driver.
// Assumes straps are valid while rst is high and one cycle after release.
`timescale 1ns/100ps
module plp_regs
  import plp_pkg::*;
#(
  parameter int unsigned BLINK0_CYCLES = BLINK0_CYC,
  parameter int unsigned BLINK1_CYCLES = BLINK1_CYC,
  parameter int unsigned BLINK2_CYCLES = BLINK2_CYC,
  parameter int unsigned BLINK3_CYCLES = BLINK3_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [DATA_W-1:0] reg_rdata,
  input wire plp_link_t link,
  input wire plp_strap_t strap,
  input wire logic led_pin_in,
  output logic status_led_output,
  output logic led_oe_n,
  output logic auto_mdix_en,
  output logic mdix_swap
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  plp_state_t q;
  plp_state_t d;
  logic pause_rx;
  logic pause_tx;
  logic act_eff;
  logic led_on;
  logic [CNT_W-1:0] period_m1;
  logic wr_led;
  logic wr_phy;

  // Period for the selected rate, as a reload value
  function automatic logic [CNT_W-1:0] rate_reload(input logic [1:0] rate);
    logic [CNT_W-1:0] r;
    r = CNT_W'(BLINK2_CYCLES - 1);
    case (rate)
      2'h0: r = CNT_W'(BLINK0_CYCLES - 1);
      2'h1: r = CNT_W'(BLINK1_CYCLES - 1);
      2'h2: r = CNT_W'(BLINK2_CYCLES - 1);
      2'h3: r = CNT_W'(BLINK3_CYCLES - 1);
      default: r = CNT_W'(BLINK2_CYCLES - 1);
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------------
  // Pause resolution
  // ---------------------------------------------------------------------
  // Bit 0 of each pair is the symmetric pause ability, bit 1 asymmetric
  always_comb begin
    pause_rx = 1'b0;
    pause_tx = 1'b0;
    if (link.hcd_full_duplex) begin
      if (link.local_pause[0] && link.partner_pause[0]) begin
        pause_rx = 1'b1;
        pause_tx = 1'b1;
      end else if (link.local_pause == 2'b10 && link.partner_pause == 2'b11) begin
        pause_tx = 1'b1;
      end else if (link.local_pause == 2'b11 && link.partner_pause == 2'b10) begin
        pause_rx = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  assign wr_led = reg_we && (reg_addr == ADDR_LED_CONTROL);
  assign wr_phy = reg_we && (reg_addr == ADDR_PHY_GENERAL_CONTROL);
  assign period_m1 = rate_reload(q.blink_rate);
  // Stretching makes short bursts visible; bypass shows the raw activity
  assign act_eff = q.bypass ? link.activity : (link.activity || q.stretch_cnt != '0);

  // LED level before polarity and forcing
  always_comb begin
    if (q.led_mode) begin
      led_on = link.link_up;
    end else begin
      led_on = link.link_up && (!act_eff || q.blink_on);
    end
  end

  always_comb begin
    d = q;
    d.rdata = '0;
    case (q.phase)
      PLP_ST_STRAP: begin
        // Pin is released during reset so the strap level can be read
        d.led_pol = led_pin_in;
        d.auto_mdix = strap.auto_mdix;
        d.led_mode = strap.led_mode;
        d.phy_addr = strap.phy_addr;
        d.phase = PLP_ST_RUN;
      end
      PLP_ST_RUN: begin
        d.phase = PLP_ST_RUN;
      end
      default: begin
        d.phase = PLP_ST_STRAP;
      end
    endcase
    // Software writes win over the strap value of the same cycle
    if (wr_led) begin
      d.blink_rate = reg_wdata[LC_RATE_LSB +: 2];
      d.led_pol = reg_wdata[LC_POL_BIT];
      d.force_sel = reg_wdata[LC_FSEL_BIT];
      d.force_val = reg_wdata[LC_FVAL_BIT];
    end
    if (wr_phy) begin
      d.auto_mdix = reg_wdata[PG_AUTO_BIT];
      d.force_mdix = reg_wdata[PG_FMDIX_BIT];
      d.bypass = reg_wdata[PG_BYP_BIT];
      d.led_mode = reg_wdata[PG_MODE_BIT];
    end
    // Read data stands only in the cycle after the strobe
    if (reg_re && reg_addr == ADDR_LED_CONTROL) begin
      d.rdata[LC_RATE_LSB +: 2] = q.blink_rate;
      d.rdata[LC_POL_BIT] = q.led_pol;
      d.rdata[LC_FSEL_BIT] = q.force_sel;
      d.rdata[LC_FVAL_BIT] = q.force_val;
    end else if (reg_re && reg_addr == ADDR_PHY_GENERAL_CONTROL) begin
      d.rdata[PG_AUTO_BIT] = q.auto_mdix;
      d.rdata[PG_FMDIX_BIT] = q.force_mdix;
      d.rdata[PG_PRX_BIT] = pause_rx;
      d.rdata[PG_PTX_BIT] = pause_tx;
      d.rdata[PG_FD_BIT] = link.link_100fd;
      d.rdata[PG_BYP_BIT] = q.bypass;
      d.rdata[PG_MODE_BIT] = q.led_mode;
      d.rdata[4:0] = q.phy_addr;
    end
    // Stretch each activity pulse for one blink period
    if (link.activity) begin
      d.stretch_cnt = period_m1;
    end else if (q.stretch_cnt != '0) begin
      d.stretch_cnt = q.stretch_cnt - CNT_W'(1);
    end
    // Blink timer runs only while activity or its stretch lasts; LED starts lit
    if (!act_eff) begin
      d.blink_cnt = period_m1;
      d.blink_on = 1'b1;
    end else if (q.blink_cnt == '0 || q.blink_cnt > period_m1) begin
      d.blink_cnt = period_m1;
      d.blink_on = !q.blink_on;
    end else begin
      d.blink_cnt = q.blink_cnt - CNT_W'(1);
    end
    // Pin level: forced value, else status at the set polarity
    if (q.force_sel) begin
      d.led_pin = q.force_val;
    end else begin
      d.led_pin = q.led_pol ? led_on : !led_on;
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q.phase <= PLP_ST_STRAP;
      q.blink_rate <= RST_BLINK_RATE;
      q.led_pol <= RST_LED_POL;
      q.force_sel <= RST_FORCE_SEL;
      q.force_val <= RST_FORCE_VAL;
      q.auto_mdix <= RST_AUTO_MDIX;
      q.force_mdix <= RST_FORCE_MDIX;
      q.bypass <= RST_BYPASS;
      q.led_mode <= RST_LED_MODE;
      q.phy_addr <= RST_PHY_ADDR;
      q.rdata <= '0;
      q.blink_cnt <= '0;
      q.blink_on <= 1'b1;
      q.stretch_cnt <= '0;
      q.led_pin <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  // Pin stays released until the strap has been taken
  assign led_oe_n = (q.phase != PLP_ST_RUN);
  assign status_led_output = q.led_pin;
  assign reg_rdata = q.rdata;
  assign auto_mdix_en = q.auto_mdix;
  assign mdix_swap = q.force_mdix;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_led_write_fval;
    wr_led && reg_wdata[LC_FVAL_BIT];
  endsequence

  sequence s_force_held;
    q.force_sel && q.phase == PLP_ST_RUN;
  endsequence

  // Read strobes of each register, used by the readback checks of the register bus group
  sequence s_read_led;
    reg_re && reg_addr == ADDR_LED_CONTROL;
  endsequence

  sequence s_read_phy;
    reg_re && reg_addr == ADDR_PHY_GENERAL_CONTROL;
  endsequence

  chk_force_pin_level: assert property (
    s_force_held |=> status_led_output == $past(q.force_val))
    else $error("Forced LED level not driven");

  chk_force_val_store: assert property (
    s_led_write_fval ##1 (reg_re && reg_addr == ADDR_LED_CONTROL && !reg_we)
      |=> reg_rdata[LC_FVAL_BIT])
    else $error("Force value bit not stored");

  chk_pause_half_dup: assert property (
    reg_re && reg_addr == ADDR_PHY_GENERAL_CONTROL && !link.hcd_full_duplex
      |=> !reg_rdata[PG_PRX_BIT] && !reg_rdata[PG_PTX_BIT])
    else $error("Pause status set without full duplex");

  chk_pause_rx_only: assert property (
    reg_re && reg_addr == ADDR_PHY_GENERAL_CONTROL && link.hcd_full_duplex
      && link.local_pause == 2'b11 && link.partner_pause == 2'b10
      |=> reg_rdata[PG_PRX_BIT] && !reg_rdata[PG_PTX_BIT])
    else $error("Asymmetric pause resolved wrongly");

  chk_fd_link_read: assert property (
    reg_re && reg_addr == ADDR_PHY_GENERAL_CONTROL
      |=> reg_rdata[PG_FD_BIT] == $past(link.link_100fd))
    else $error("Full-duplex link status misreported");

  chk_mdix_write: assert property (
    wr_phy |=> mdix_swap == $past(reg_wdata[PG_FMDIX_BIT]))
    else $error("Forced crossover not applied");

  chk_auto_mdix_write: assert property (
    wr_phy |=> auto_mdix_en == $past(reg_wdata[PG_AUTO_BIT]))
    else $error("Auto crossover enable not applied");

  chk_link_mode_pol: assert property (
    q.phase == PLP_ST_RUN && !q.force_sel && q.led_mode
      |=> status_led_output == ($past(q.led_pol) ? $past(link.link_up) : !$past(link.link_up)))
    else $error("LED link mode level or polarity wrong");

  chk_bypass_raw: assert property (
    q.phase == PLP_ST_RUN && !q.force_sel && !q.led_mode && q.bypass
      && link.link_up && !link.activity
      |=> status_led_output == $past(q.led_pol))
    else $error("Bypassed LED not steady on while idle");

  chk_addr_read: assert property (
    reg_re && reg_addr == ADDR_PHY_GENERAL_CONTROL
      |=> reg_rdata[4:0] == $past(q.phy_addr))
    else $error("PHY address readback wrong");

  chk_blink_toggle: assert property (
    act_eff && q.blink_cnt == '0 |=> q.blink_on != $past(q.blink_on))
    else $error("Blink phase did not toggle at period end");

  chk_blink_reload: assert property (
    act_eff && q.blink_cnt == '0 |=> q.blink_cnt == $past(period_m1))
    else $error("Blink period reload wrong");

  // Mid-period the phase holds and the counter steps down by one
  chk_blink_hold: assert property (
    act_eff && q.blink_cnt != '0 && q.blink_cnt <= period_m1
      |=> q.blink_on == $past(q.blink_on) && q.blink_cnt == $past(q.blink_cnt) - CNT_W'(1))
    else $error("Blink phase changed before period end");

  // Without activity the timer parks at a full period with the LED lit
  chk_blink_idle_on: assert property (
    !act_eff |=> q.blink_on && q.blink_cnt == $past(period_m1))
    else $error("Blink timer not parked while idle");

  // Every activity pulse restarts the stretch window
  chk_stretch_load: assert property (
    link.activity |=> q.stretch_cnt == $past(period_m1))
    else $error("Stretch window not restarted by activity");

  // Off phase of the activity blink drives the inactive level
  chk_blink_off_phase: assert property (
    q.phase == PLP_ST_RUN && !q.force_sel && !q.led_mode && link.link_up && act_eff
      && !q.blink_on |=> status_led_output == !$past(q.led_pol))
    else $error("LED not dark during blink off phase");

  // No link means a dark LED in either display mode
  chk_no_link_off: assert property (
    q.phase == PLP_ST_RUN && !q.force_sel && !link.link_up
      |=> status_led_output == !$past(q.led_pol))
    else $error("LED lit without link");

  // ---------------------------------------------------------------------
  // Register bus checks
  // ---------------------------------------------------------------------
  // A write lands in the next cycle; a strap of the same cycle loses
  chk_led_write: assert property (
    wr_led |=> q.blink_rate == $past(reg_wdata[LC_RATE_LSB +: 2])
      && q.led_pol == $past(reg_wdata[LC_POL_BIT])
      && q.force_sel == $past(reg_wdata[LC_FSEL_BIT]))
    else $error("LED control write not applied");

  chk_phy_write: assert property (
    wr_phy |=> q.bypass == $past(reg_wdata[PG_BYP_BIT])
      && q.led_mode == $past(reg_wdata[PG_MODE_BIT]))
    else $error("Bypass or display mode write not applied");

  chk_led_readback: assert property (
    s_read_led |=> reg_rdata[LC_RATE_LSB +: 2] == $past(q.blink_rate)
      && reg_rdata[LC_POL_BIT] == $past(q.led_pol)
      && reg_rdata[LC_FSEL_BIT] == $past(q.force_sel))
    else $error("LED control readback wrong");

  // Both sides symmetric: pause in both directions
  chk_pause_both: assert property (
    s_read_phy ##0 (link.hcd_full_duplex && link.local_pause[0] && link.partner_pause[0])
      |=> reg_rdata[PG_PRX_BIT] && reg_rdata[PG_PTX_BIT])
    else $error("Symmetric pause not resolved to both directions");

  chk_pause_tx_only: assert property (
    s_read_phy ##0 (link.hcd_full_duplex && link.local_pause == 2'h2
      && link.partner_pause == 2'h3) |=> !reg_rdata[PG_PRX_BIT] && reg_rdata[PG_PTX_BIT])
    else $error("Transmit-only pause resolved wrongly");

  // Straps land at the first edge after release unless software writes then
  chk_strap_capture: assert property (
    q.phase == PLP_ST_STRAP && !reg_we
      |=> q.led_pol == $past(led_pin_in) && auto_mdix_en == $past(strap.auto_mdix)
      && q.led_mode == $past(strap.led_mode) && q.phy_addr == $past(strap.phy_addr))
    else $error("Strap values not captured after reset");

  // The pin is driven as soon as the strap has been read
  chk_oe_after_strap: assert property (
    q.phase == PLP_ST_STRAP |=> !led_oe_n)
    else $error("LED pin not driven after strap capture");

endmodule

// ---- design/plp_pkg.sv ----
// Package for the LED and PHY control register pair.
// Assumes a 125 MHz system clock and a 5-bit management register address.
package plp_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam logic [4:0] ADDR_LED_CONTROL = 5'h18;
  localparam logic [4:0] ADDR_PHY_GENERAL_CONTROL = 5'h19;

  // led_control field positions
  localparam int unsigned LC_RATE_LSB = 9;
  localparam int unsigned LC_POL_BIT = 7;
  localparam int unsigned LC_FSEL_BIT = 4;
  localparam int unsigned LC_FVAL_BIT = 1;

  // phy_general_control field positions
  localparam int unsigned PG_AUTO_BIT = 15;
  localparam int unsigned PG_FMDIX_BIT = 14;
  localparam int unsigned PG_PRX_BIT = 13;
  localparam int unsigned PG_PTX_BIT = 12;
  localparam int unsigned PG_FD_BIT = 11;
  localparam int unsigned PG_BYP_BIT = 7;
  localparam int unsigned PG_MODE_BIT = 5;

  // Values after reset (straps replace some of them at release)
  localparam logic [1:0] RST_BLINK_RATE = 2'h2;
  localparam logic RST_LED_POL = 1'b0;
  localparam logic RST_FORCE_VAL = 1'b0;
  localparam logic RST_FORCE_SEL = 1'b0;
  localparam logic RST_AUTO_MDIX = 1'b0;
  localparam logic RST_FORCE_MDIX = 1'b0;
  localparam logic RST_BYPASS = 1'b0;
  localparam logic RST_LED_MODE = 1'b1;
  localparam logic [4:0] RST_PHY_ADDR = 5'h01;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned BLINK0_MS = 50;
  localparam int unsigned BLINK1_MS = 100;
  localparam int unsigned BLINK2_MS = 200;
  localparam int unsigned BLINK3_MS = 500;
  localparam int unsigned BLINK0_CYC = BLINK0_MS * CLK_KHZ;
  localparam int unsigned BLINK1_CYC = BLINK1_MS * CLK_KHZ;
  localparam int unsigned BLINK2_CYC = BLINK2_MS * CLK_KHZ;
  localparam int unsigned BLINK3_CYC = BLINK3_MS * CLK_KHZ;
  localparam int unsigned CNT_W = 26;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    PLP_ST_STRAP = 2'b01,
    PLP_ST_RUN = 2'b10
  } plp_phase_t;

  // Link-side status that the block reports or reacts to
  typedef struct packed {
    logic link_up;
    logic activity;
    logic link_100fd;
    logic hcd_full_duplex;
    logic [1:0] local_pause;
    logic [1:0] partner_pause;
  } plp_link_t;

  // Values sampled from strap pins at reset release
  typedef struct packed {
    logic auto_mdix;
    logic led_mode;
    logic [4:0] phy_addr;
  } plp_strap_t;

  typedef struct packed {
    plp_phase_t phase;
    logic [1:0] blink_rate;
    logic led_pol;
    logic force_sel;
    logic force_val;
    logic auto_mdix;
    logic force_mdix;
    logic bypass;
    logic led_mode;
    logic [4:0] phy_addr;
    logic [DATA_W-1:0] rdata;
    logic [CNT_W-1:0] blink_cnt;
    logic blink_on;
    logic [CNT_W-1:0] stretch_cnt;
    logic led_pin;
  } plp_state_t;

endpackage

// ---- testbench/tb.sv ----
// Self-checking bench for the LED control and PHY general control registers.
// Assumes plp_regs from design/ and plp_pkg compiled first; short blink periods.
`timescale 1ns/100ps
module tb
  import plp_pkg::*;
;
  // ---------------------------------------------------------------------
  // Clock, stimulus and counters
  // ---------------------------------------------------------------------
  localparam int unsigned PER[4] = '{4, 8, 16, 40};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [15:0] reg_rdata;
  plp_link_t link = '0;
  plp_strap_t strap = '{auto_mdix: 1'b1, led_mode: 1'b1, phy_addr: 5'h0a};
  logic led_pin_in = 1'b1;
  logic status_led_output, led_oe_n, auto_mdix_en, mdix_swap;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [15:0] d;
  int n;

  // Half period of 4 ns gives 125 MHz
  always #4 sys_clk = ~sys_clk;

  plp_regs #(.BLINK0_CYCLES(4), .BLINK1_CYCLES(8), .BLINK2_CYCLES(16),
    .BLINK3_CYCLES(40)) dut_u (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .link(link), .strap(strap), .led_pin_in(led_pin_in),
    .status_led_output(status_led_output), .led_oe_n(led_oe_n),
    .auto_mdix_en(auto_mdix_en), .mdix_swap(mdix_swap));

  // ---------------------------------------------------------------------
  // Shared tasks: bus cycles, comparison, verdict
  // ---------------------------------------------------------------------
  task automatic results();
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Called just after a rising edge; a spare edge follows so strobes never re-rise at once
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_we <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Read data stand only in the cycle after the strobe, so sample at that negedge
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
    @(posedge sys_clk);
  endtask

  // Bounded wait for the LED pin to reach a level; k returns the cycles spent
  task automatic wait_led(input logic v, output int k);
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (status_led_output !== v && k < 300);
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset();
    @(negedge sys_clk);
    chk({15'h0, led_oe_n}, 16'h0001);
    chk({14'h0, auto_mdix_en, mdix_swap}, 16'h0000);
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd(ADDR_LED_CONTROL, d);
    chk(d, 16'h0480);
    rd(ADDR_PHY_GENERAL_CONTROL, d);
    chk(d, 16'h802a);
    chk({14'h0, auto_mdix_en, led_oe_n}, 16'h0002);
  endtask

  task automatic t_rw();
    wr(ADDR_LED_CONTROL, 16'hffff);
    rd(ADDR_LED_CONTROL, d);
    chk(d, 16'h0692);
    chk({15'h0, status_led_output}, 16'h0001);
    wr(ADDR_LED_CONTROL, 16'h0410);
    @(negedge sys_clk);
    chk({15'h0, status_led_output}, 16'h0000);
    @(posedge sys_clk);
    wr(ADDR_PHY_GENERAL_CONTROL, 16'hffff);
    rd(ADDR_PHY_GENERAL_CONTROL, d);
    chk(d, 16'hc0aa);
    chk({14'h0, auto_mdix_en, mdix_swap}, 16'h0003);
    wr(ADDR_PHY_GENERAL_CONTROL, 16'h0000);
    rd(ADDR_PHY_GENERAL_CONTROL, d);
    chk(d, 16'h000a);
    chk({14'h0, auto_mdix_en, mdix_swap}, 16'h0000);
    // Unmapped address: write dropped, read gives zero
    wr(5'h05, 16'hffff);
    rd(5'h05, d);
    chk(d, 16'h0000);
    // Write then read with no idle cycle between the strobes
    reg_we <= 1'b1;
    reg_addr <= ADDR_LED_CONTROL;
    reg_wdata <= 16'h0402;
    @(posedge sys_clk);
    reg_we <= 1'b0;
    reg_re <= 1'b1;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, 16'h0402);
    @(posedge sys_clk);
  endtask

  // Link-only display in both polarities
  task automatic t_mode1();
    wr(ADDR_PHY_GENERAL_CONTROL, 16'h0020);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_LED_CONTROL, i[1] ? 16'h0480 : 16'h0400);
      link.link_up <= i[0];
      repeat (2) @(negedge sys_clk);
      chk({15'h0, status_led_output}, {15'h0, i[0] ~^ i[1]});
      @(posedge sys_clk);
    end
  endtask

  // Every pair of advertised pause settings, with and without full duplex
  task automatic t_pause();
    logic [1:0] l, p;
    logic rx, tx;
    for (int i = 0; i < 32; i++) begin
      l = i[1:0];
      p = i[3:2];
      link.local_pause <= l;
      link.partner_pause <= p;
      link.hcd_full_duplex <= i[4];
      link.link_100fd <= i[0] ^ i[4];
      @(posedge sys_clk);
      rx = i[4] & ((l[0] & p[0]) | (l == 2'h3 && p == 2'h2));
      tx = i[4] & ((l[0] & p[0]) | (l == 2'h2 && p == 2'h3));
      rd(ADDR_PHY_GENERAL_CONTROL, d);
      chk({13'h0, d[13:11]}, {13'h0, rx, tx, i[0] ^ i[4]});
    end
  endtask

  // Off phase of the activity blink at every rate, then stretch on and off
  task automatic t_blink();
    wr(ADDR_PHY_GENERAL_CONTROL, 16'h0080);
    link.link_up <= 1'b1;
    link.activity <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_LED_CONTROL, 16'h0080 | (16'(r) << 9));
      wait_led(1'b1, n);
      wait_led(1'b0, n);
      wait_led(1'b1, n);
      chk(16'(n), 16'(PER[r]));
      @(posedge sys_clk);
    end
    // Bypass: dropping activity in an off phase turns the LED straight back on
    wait_led(1'b0, n);
    @(posedge sys_clk);
    link.activity <= 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({15'h0, status_led_output}, 16'h0001);
    @(posedge sys_clk);
    wr(ADDR_PHY_GENERAL_CONTROL, 16'h0000);
    link.activity <= 1'b1;
    wait_led(1'b1, n);
    wait_led(1'b0, n);
    @(posedge sys_clk);
    link.activity <= 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({15'h0, status_led_output}, 16'h0000);
  endtask

  // ---------------------------------------------------------------------
  // Watchdog and main sequence
  // ---------------------------------------------------------------------
  // Whole run needs about 360 cycles; over fifty times that means a hang
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  initial begin
    t_reset();
    t_rw();
    t_mode1();
    t_pause();
    t_blink();
    results();
  end
endmodule
